// ### inc/fpg_pkg.sv
package fpg_pkg;

	// ==========================================================
	// bus timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_PHQV_NS     = 150;
	localparam int T_PHWL_NS     = 150;
	localparam int T_RD_NS       = 100;
	localparam int T_WP_NS       = 60;
	localparam int SYNC_CYC      = 3;
	// least times round up to whole cycles
	localparam int PHQV_CYC = (T_PHQV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PHWL_CYC = (T_PHWL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC   = (T_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REC_CYC  = (PHQV_CYC > PHWL_CYC) ? PHQV_CYC : PHWL_CYC;
	localparam int CNT_W    = 8;

	// ==========================================================
	// command codes and status fields
	localparam logic [15:0] CMD_READ_ARRAY   = 16'h00FF;
	localparam int          SUPPLY_ERROR_BIT = 3;

	// ==========================================================
	// controller states, gray in declaration order
	typedef enum logic [2:0] {
		ST_PWRDN   = 3'b000,
		ST_RECOVER = 3'b001,
		ST_IDLE    = 3'b011,
		ST_RD      = 3'b010,
		ST_WR      = 3'b110,
		ST_HOLD    = 3'b111
	} fpg_state_type;

endpackage

// ### inc/fpg_sync_if.sv
`timescale 1ns/1ns
interface fpg_sync_if #(parameter int W = 17);
	logic [W-1:0] pin_raw;
	// one driver per bit from the generate loop, so a net
	wire logic [W-1:0] pin_clean;
	modport sync (input pin_raw, output pin_clean);
	modport user (output pin_raw, input pin_clean);
endinterface

// ### design/fpg_pin_sync.sv
`timescale 1ns/1ns
module fpg_pin_sync #(
	parameter int W = 17
) (
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	fpg_sync_if.sync   pins
);
	import fpg_pkg::*;

	// ==========================================================
	// three stages; a bit moves only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			logic out_ff;
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					s1_ff  <= 1'b0;
					s2_ff  <= 1'b0;
					s3_ff  <= 1'b0;
					out_ff <= 1'b0;
				end
				else
				begin
					s1_ff <= pins.pin_raw[g];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff)
						out_ff <= s3_ff;
				end
			end
			assign pins.pin_clean[g] = out_ff;
		end
	endgenerate

endmodule // fpg_pin_sync

// ### design/fpg_flash_host.sv
`timescale 1ns/1ns
module fpg_flash_host
	import fpg_pkg::*;
#(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16
) (
	// clock and reset
	input  wire logic              CLK_SYS_I,
	input  wire logic              RST_I,
	// user request side
	input  wire logic              REQ_VALID_I,
	input  wire logic              REQ_WRITE_I,
	input  wire logic              REQ_ARRAY_I,
	input  wire logic [ADDR_W-1:0] REQ_ADDR_I,
	input  wire logic [DATA_W-1:0] REQ_WDATA_I,
	output logic                   REQ_READY_O,
	output logic                   RSP_VALID_O,
	output logic [DATA_W-1:0]      RSP_RDATA_O,
	output logic                   RSP_SUPPLY_ERR_O,
	output logic                   ABORT_O,
	// power control
	input  wire logic              PWRDN_REQ_I,
	input  wire logic              SUPPLY_OK_I,
	// flash pins
	output logic                   CE_N_O,
	output logic                   OE_N_O,
	output logic                   WE_N_O,
	output logic                   RESET_POWERDOWN_N_O,
	output logic [ADDR_W-1:0]      ADDR_O,
	output logic [DATA_W-1:0]      DQ_O,
	output logic                   DQ_OE_O,
	input  wire logic [DATA_W-1:0] DQ_I
);
	import fpg_pkg::*;

	// ==========================================================
	// pin synchroniser: data bus plus supply-good level
	fpg_sync_if #(.W(DATA_W + 1)) sif ();
	assign sif.pin_raw = {SUPPLY_OK_I, DQ_I};

	fpg_pin_sync #(.W(DATA_W + 1)) u_sync (
		.clk_i (CLK_SYS_I),
		.rst_i (RST_I),
		.pins  (sif.sync)
	);

	logic [DATA_W-1:0] dq_clean;
	logic              supply_ok;
	assign dq_clean  = sif.pin_clean[DATA_W-1:0];
	assign supply_ok = sif.pin_clean[DATA_W];

	// ==========================================================
	// state
	fpg_state_type     state_ff;
	logic [CNT_W-1:0]  cnt_ff;
	logic              array_mode_ff;
	logic              op_pending_ff;
	logic              pend_read_ff;
	logic              rd_array_ff;
	logic [ADDR_W-1:0] lat_addr_ff;
	logic              hold_rp;
	logic              need_ra;

	// supply swings and power-down requests keep the part in reset
	assign hold_rp = PWRDN_REQ_I | ~supply_ok;
	assign need_ra = ~REQ_WRITE_I & REQ_ARRAY_I & ~array_mode_ff;
	assign REQ_READY_O = (state_ff == ST_IDLE) & ~hold_rp;

	localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(REC_CYC - 1);
	localparam logic [CNT_W-1:0] RD_LAST  = CNT_W'(RD_CYC + SYNC_CYC);
	localparam logic [CNT_W-1:0] WP_LAST  = CNT_W'(WP_CYC - 1);

	// ==========================================================
	// sequencer and pin drive
	always_ff @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			state_ff            <= ST_PWRDN;
			cnt_ff              <= '0;
			RESET_POWERDOWN_N_O <= 1'b0;
			CE_N_O              <= 1'b1;
			OE_N_O              <= 1'b1;
			WE_N_O              <= 1'b1;
			DQ_OE_O             <= 1'b0;
			DQ_O                <= '0;
			ADDR_O              <= '0;
			lat_addr_ff         <= '0;
			pend_read_ff        <= 1'b0;
			rd_array_ff         <= 1'b0;
		end
		else if (hold_rp && state_ff != ST_PWRDN)
		begin
			// deep power-down drops any cycle in flight
			state_ff            <= ST_PWRDN;
			RESET_POWERDOWN_N_O <= 1'b0;
			CE_N_O              <= 1'b1;
			OE_N_O              <= 1'b1;
			WE_N_O              <= 1'b1;
			DQ_OE_O             <= 1'b0;
			pend_read_ff        <= 1'b0;
		end
		else
		begin
			case (state_ff)
				ST_PWRDN:
				begin
					if (!hold_rp)
					begin
						RESET_POWERDOWN_N_O <= 1'b1;
						cnt_ff              <= '0;
						state_ff            <= ST_RECOVER;
					end
				end
				ST_RECOVER:
				begin
					// no strobe until both recovery times pass
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == REC_LAST)
						state_ff <= ST_IDLE;
				end
				ST_IDLE:
				begin
					cnt_ff <= '0;
					if (REQ_VALID_I)
					begin
						lat_addr_ff <= REQ_ADDR_I;
						rd_array_ff <= REQ_ARRAY_I;
						ADDR_O      <= REQ_ADDR_I;
						CE_N_O      <= 1'b0;
						if (REQ_WRITE_I || need_ra)
						begin
							// write pulse only with chip enable low
							WE_N_O       <= 1'b0;
							DQ_OE_O      <= 1'b1;
							DQ_O         <= need_ra ? CMD_READ_ARRAY
							                        : REQ_WDATA_I;
							pend_read_ff <= need_ra;
							state_ff     <= ST_WR;
						end
						else
						begin
							OE_N_O   <= 1'b0;
							state_ff <= ST_RD;
						end
					end
				end
				ST_RD:
				begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == RD_LAST)
					begin
						// chip enable high puts the part in standby
						CE_N_O   <= 1'b1;
						OE_N_O   <= 1'b1;
						state_ff <= ST_HOLD;
					end
				end
				ST_WR:
				begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == WP_LAST)
					begin
						// the part finishes its operation in standby
						WE_N_O   <= 1'b1;
						CE_N_O   <= 1'b1;
						state_ff <= ST_HOLD;
					end
				end
				ST_HOLD:
				begin
					// data held one cycle past the write edge
					DQ_OE_O <= 1'b0;
					cnt_ff  <= '0;
					if (pend_read_ff)
					begin
						pend_read_ff <= 1'b0;
						ADDR_O       <= lat_addr_ff;
						CE_N_O       <= 1'b0;
						OE_N_O       <= 1'b0;
						state_ff     <= ST_RD;
					end
					else
						state_ff <= ST_IDLE;
				end
				default:
					state_ff <= ST_PWRDN;
			endcase
		end
	end

	// ==========================================================
	// mirror of the device command decoder mode
	always_ff @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			array_mode_ff <= 1'b1;
			op_pending_ff <= 1'b0;
			ABORT_O       <= 1'b0;
		end
		else
		begin
			ABORT_O <= 1'b0;
			if (!RESET_POWERDOWN_N_O)
			begin
				// device leaves reset in read-array mode
				array_mode_ff <= 1'b1;
				op_pending_ff <= 1'b0;
			end
			else if (hold_rp && state_ff != ST_PWRDN)
				ABORT_O <= op_pending_ff;
			else if (state_ff == ST_WR && cnt_ff == WP_LAST)
			begin
				array_mode_ff <= (DQ_O == CMD_READ_ARRAY);
				op_pending_ff <= (DQ_O != CMD_READ_ARRAY);
			end
		end
	end

	// ==========================================================
	// read answer; status reads expose the supply error bit
	always_ff @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			RSP_VALID_O      <= 1'b0;
			RSP_RDATA_O      <= '0;
			RSP_SUPPLY_ERR_O <= 1'b0;
		end
		else
		begin
			RSP_VALID_O <= 1'b0;
			if (state_ff == ST_RD && cnt_ff == RD_LAST && !hold_rp)
			begin
				RSP_VALID_O      <= 1'b1;
				RSP_RDATA_O      <= dq_clean;
				RSP_SUPPLY_ERR_O <= ~rd_array_ff
				                  & dq_clean[SUPPLY_ERROR_BIT];
			end
		end
	end

	// ==========================================================
	// checks
	logic [CNT_W-1:0] since_rp_ff;
	always_ff @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
			since_rp_ff <= '0;
		else if (!RESET_POWERDOWN_N_O)
			since_rp_ff <= '0;
		else if (since_rp_ff != '1)
			since_rp_ff <= since_rp_ff + 1'b1;
	end

	AST_WE_NEEDS_CE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!WE_N_O |-> !CE_N_O) else $error("write strobe without chip enable");
	AST_WR_RECOVERY: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		$fell(WE_N_O) |-> since_rp_ff >= CNT_W'(PHWL_CYC)) else $error("write too soon after reset");
	AST_RD_RECOVERY: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		RSP_VALID_O |-> since_rp_ff > CNT_W'(PHQV_CYC)) else $error("read too soon after reset");
	AST_RST_HOLDS_RP: assert property (@(posedge CLK_SYS_I) disable iff (1'b0)
		RST_I |-> !RESET_POWERDOWN_N_O) else $error("system reset left flash out of reset");
	AST_SUPPLY_RP: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!supply_ok |-> ##1 !RESET_POWERDOWN_N_O) else $error("reset not held in supply swing");
	AST_ARRAY_READ: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(state_ff == ST_RD && rd_array_ff) |-> array_mode_ff) else $error("array read outside read-array");
	AST_RA_CODE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		($rose(array_mode_ff) && $past(RESET_POWERDOWN_N_O)) |-> $past(DQ_O) == CMD_READ_ARRAY) else $error("array mode without command");

	COV_READ:    cover property (@(posedge CLK_SYS_I) disable iff (RST_I) RSP_VALID_O);
	COV_WRITE:   cover property (@(posedge CLK_SYS_I) disable iff (RST_I) $rose(WE_N_O));
	COV_AUTO_RA: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) pend_read_ff && state_ff == ST_HOLD);
	COV_ABORT:   cover property (@(posedge CLK_SYS_I) disable iff (RST_I) ABORT_O);

endmodule // fpg_flash_host

// ### test/fpg_flash_model.sv
`timescale 1ns/1ns
// ==========================================================
// behavioural flash device, sixteen words of array
module fpg_flash_model (
	// strobes
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        rp_n_i,
	input  wire logic        vpp_ok_i,
	// bus
	input  wire logic [19:0] addr_i,
	input  wire logic [15:0] dq_i,
	output logic      [15:0] dq_o
);
	logic [15:0] mem [16];
	logic [7:0]  sr;
	logic [7:0]  cmd;
	logic        rd_arr;
	logic [15:0] last;
	logic [15:0] val;
	wire         drv = ~ce_n_i & ~oe_n_i & rp_n_i;
	wire         wa  = ~we_n_i & ~ce_n_i & rp_n_i;
	initial
	begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		sr = 8'h80;
		cmd = 8'hFF;
		rd_arr = 1'b1;
		last = 16'h0000;
	end
	// ==========================================================
	// reset pin low: clear status, back to array mode
	always @(negedge rp_n_i)
	begin
		sr = 8'h80;
		cmd = 8'hFF;
		rd_arr = 1'b1;
	end
	// ==========================================================
	// command decoder; program finishes at once, so chip enable
	// rising can never cut it short
	always @(negedge wa)
	begin
		if (rp_n_i && cmd == 8'h40)
		begin
			if (!vpp_ok_i) sr = sr | 8'h18;
			else mem[addr_i[3:0]] = mem[addr_i[3:0]] & dq_i;
			cmd = 8'h70;
			rd_arr = 1'b0;
		end
		else if (rp_n_i)
		begin
			cmd = dq_i[7:0];
			rd_arr = (dq_i[7:0] == 8'hFF);
			if (dq_i[7:0] == 8'h50) sr = 8'h80;
		end
	end
	// ==========================================================
	// outputs hold while address is idle; released bus shows
	// the inverse of the last word so no stale value survives
	assign val = rd_arr ? mem[addr_i[3:0]] : {8'h00, sr};
	always @* if (drv) last = val;
	assign dq_o = drv ? val : ~last;
endmodule // fpg_flash_model

// ### test/tb_flash_power_mode_write_guard.sv
`timescale 1ns/1ns
module tb_flash_power_mode_write_guard;
	import fpg_pkg::*;
	logic        clk = 0, rst = 0, vld = 0, wr = 0, arr = 0;
	logic        pdn = 0, sok = 1, vpp = 1, seen_abort = 0;
	logic [19:0] a = 0, ao;
	logic [15:0] wd = 0, rdat, dqo, mdq, d;
	logic        rdy, rv, serr, abrt, ce_n, oe_n, we_n, rp_n, doe, e;
	wire  [15:0] bus = doe ? dqo : mdq;
	int          bad_count = 0, n_tests = 0, cyc = 0, rec = 0;
	always #5 clk = ~clk;
	fpg_flash_host dut (.CLK_SYS_I(clk), .RST_I(rst), .REQ_VALID_I(vld),
		.REQ_WRITE_I(wr), .REQ_ARRAY_I(arr), .REQ_ADDR_I(a),
		.REQ_WDATA_I(wd), .REQ_READY_O(rdy), .RSP_VALID_O(rv),
		.RSP_RDATA_O(rdat), .RSP_SUPPLY_ERR_O(serr), .ABORT_O(abrt),
		.PWRDN_REQ_I(pdn), .SUPPLY_OK_I(sok), .CE_N_O(ce_n),
		.OE_N_O(oe_n), .WE_N_O(we_n), .RESET_POWERDOWN_N_O(rp_n),
		.ADDR_O(ao), .DQ_O(dqo), .DQ_OE_O(doe), .DQ_I(bus));
	fpg_flash_model flash (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
		.rp_n_i(rp_n), .vpp_ok_i(vpp), .addr_i(ao), .dq_i(bus),
		.dq_o(mdq));
	// ==========================================================
	// checking helpers
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		rec <= rp_n ? rec + 1 : 0;
		if (abrt) seen_abort <= 1'b1;
		if (cyc == 5000)
		begin
			bad_count++;
			finish_test;
		end
	end
	// first strobe after reset pin rises must respect recovery
	always @(negedge ce_n) chk(16'(rec >= REC_CYC), 16'h0001);
	// ==========================================================
	// bus requests
	task req(input logic w, input logic ar, input logic [19:0] ad,
		input logic [15:0] dat);
		int k;
		@(negedge clk);
		vld = 1;
		wr = w;
		arr = ar;
		a = ad;
		wd = dat;
		k = 0;
		do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 300);
		chk(16'(rdy === 1'b1), 16'h0001);
		@(negedge clk);
		vld = 0;
	endtask
	task rd(input logic ar, input logic [19:0] ad);
		int k;
		req(1'b0, ar, ad, 16'h0000);
		k = 0;
		while (rv !== 1'b1 && k < 100)
		begin
			@(negedge clk);
			k++;
		end
		chk(16'(rv), 16'h0001);
		d = rdat;
		e = serr;
	endtask
	task wait_rdy;
		int k;
		k = 0;
		while (rdy !== 1'b1 && k < 100)
		begin
			@(negedge clk);
			k++;
		end
		chk(16'(rdy), 16'h0001);
	endtask
	// ==========================================================
	// scenarios
	task t_prog;
		wait_rdy();
		req(1'b1, 1'b0, 20'h00003, 16'h0040);
		req(1'b1, 1'b0, 20'h00003, 16'h1234);
		rd(1'b0, 20'h00000);
		chk(d, 16'h0080);
		chk(16'(e), 16'h0000);
		rd(1'b1, 20'h00003);
		chk(d, 16'h1234);
		req(1'b1, 1'b0, 20'h00006, 16'h0011);
		req(1'b1, 1'b0, 20'h00006, 16'h0000);
		rd(1'b1, 20'h00006);
		chk(d, 16'hFFFF);
		$display("test program done");
	endtask
	task t_lock_pdn;
		vpp = 0;
		req(1'b1, 1'b0, 20'h00005, 16'h0040);
		req(1'b1, 1'b0, 20'h00005, 16'hBEEF);
		rd(1'b0, 20'h00000);
		chk(d, 16'h0098);
		chk(16'(e), 16'h0001);
		vpp = 1;
		pdn = 1;
		repeat (20) @(negedge clk);
		chk(16'(rp_n), 16'h0000);
		chk(16'(rdy), 16'h0000);
		chk(16'(seen_abort), 16'h0001);
		pdn = 0;
		rd(1'b1, 20'h00005);
		chk(d, 16'hFFFF);
		rd(1'b1, 20'h00003);
		chk(d, 16'h1234);
		req(1'b1, 1'b0, 20'h00000, 16'h0070);
		rd(1'b0, 20'h00000);
		chk(d, 16'h0080);
		$display("test lockout and power-down done");
	endtask
	task t_supply;
		wait_rdy();
		sok = 0;
		repeat (10) @(negedge clk);
		chk(16'(rp_n), 16'h0000);
		chk(16'(rdy), 16'h0000);
		sok = 1;
		rd(1'b1, 20'h00003);
		chk(d, 16'h1234);
		$display("test supply drop done");
	endtask
	initial
	begin
		// raise reset off the clock edge so the async reset sees an edge
		#1 rst = 1;
		repeat (16) @(negedge clk);
		chk(16'(rp_n), 16'h0000);
		rst = 0;
		t_prog();
		t_lock_pdn();
		t_supply();
		finish_test();
	end
endmodule // tb_flash_power_mode_write_guard
